/* hw/rpm_pkg.sv */
// ============================================================
// Shared constants for the reset and power mode controller
package rpm_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // ============================================================
  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_CAUSE = 8'h08;
  localparam logic [7:0] OFF_SWRST = 8'h0C;
  localparam logic [7:0] OFF_WAKE = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // ============================================================
  // Power modes
  typedef enum logic [1:0] {
    RPM_RUN = 2'b00,
    RPM_IDLE = 2'b01,
    RPM_PD = 2'b10,
    RPM_TPD = 2'b11
  } rpm_mode_type;
  // ============================================================
  // Reset cause bits
  localparam int unsigned CAUSE_W = 6;
  localparam int unsigned CS_PIN = 0;
  localparam int unsigned CS_POR = 1;
  localparam int unsigned CS_BOD = 2;
  localparam int unsigned CS_WDT = 3;
  localparam int unsigned CS_SW = 4;
  localparam int unsigned CS_BRK = 5;
  localparam logic [5:0] CAUSE_POR_VAL = 6'h06;
  // ============================================================
  // Field positions
  localparam int unsigned MD_REQ_LSB = 0;
  localparam int unsigned MD_CMP_PD = 2;
  localparam int unsigned MD_RTC_EN = 3;
  localparam int unsigned MD_RC_SEL = 4;
  localparam int unsigned CF_RPE = 0;
  localparam int unsigned CF_BOE = 1;
  localparam int unsigned CF_BOI = 2;
  localparam int unsigned CF_BSTAT = 3;
  localparam int unsigned CF_BVEC_LSB = 8;
  localparam int unsigned SW_GO = 0;
  localparam int unsigned ST_PIN = 16;
  localparam int unsigned ST_BOIRQ = 17;
  localparam int unsigned ST_RESET = 18;
  // ============================================================
  // Reset values and vectors
  localparam logic RPE_RST = 1'b0;
  localparam logic BOE_RST = 1'b1;
  localparam logic BOI_RST = 1'b0;
  localparam logic BSTAT_RST = 1'b0;
  localparam logic [7:0] BVEC_RST = 8'hF0;
  localparam logic [15:0] START_ADDR = 16'h0000;
  localparam logic [7:0] BOOT_LOW = 8'h00;
  localparam int unsigned RST_HOLD_DEF = 8;
endpackage

/* hw/rpm_link_if.sv */
`timescale 1ns/10ps
// ============================================================
// Link between the top and its mode and vector units
interface rpm_link_if #(
  parameter int unsigned IRQ_W = 8
);
  logic reset_req, mode_req_valid, cmp_pd, rtc_en, rc_sel, bod_en_cfg;
  rpm_pkg::rpm_mode_type mode_req, mode;
  logic [IRQ_W-1:0] irq, wake_en;
  logic cpu_clk_en, periph_clk_en, osc_main_en, rc_osc_en;
  logic bod_run, cmp_run, rtc_run, wdt_run;
  logic por_active, isp_strap, brk_req, boot_stat0;
  logic [7:0] boot_vec;
  logic [15:0] fetch_addr;
  modport ctl (
    output reset_req, mode_req_valid, mode_req, cmp_pd, rtc_en, rc_sel, bod_en_cfg,
    output irq, wake_en, por_active, isp_strap, brk_req, boot_stat0, boot_vec,
    input mode, cpu_clk_en, periph_clk_en, osc_main_en, rc_osc_en,
    input bod_run, cmp_run, rtc_run, wdt_run, fetch_addr
  );
  modport pwr (
    input reset_req, mode_req_valid, mode_req, cmp_pd, rtc_en, rc_sel, bod_en_cfg,
    input irq, wake_en,
    output mode, cpu_clk_en, periph_clk_en, osc_main_en, rc_osc_en,
    output bod_run, cmp_run, rtc_run, wdt_run
  );
  modport vec (
    input reset_req, por_active, isp_strap, brk_req, boot_stat0, boot_vec,
    output fetch_addr
  );
endinterface // rpm_link_if

/* hw/rpm_mode_ctrl.sv */
`timescale 1ns/10ps
// ============================================================
// Power mode state and block gating
module rpm_mode_ctrl #(
  parameter int unsigned IRQ_W = 8,
  parameter logic [IRQ_W-1:0] PD_WAKE_MASK = '1
) (
  // System
  input logic clk_sys,
  input logic rst,
  // Link
  rpm_link_if.pwr bus
);
  typedef struct packed {
    rpm_pkg::rpm_mode_type mode;
    logic cpu_clk_en, periph_clk_en, osc_main_en, rc_osc_en;
    logic bod_run, cmp_run, rtc_run, wdt_run;
  } rpm_mode_state_type;
  localparam rpm_mode_state_type MODE_RST = '{rpm_pkg::RPM_RUN,
    1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  rpm_mode_state_type s_q, s_d;
  logic wake_any, wake_pd, low_pwr;

  always_comb begin
    s_d = s_q;
    wake_any = |(bus.irq & bus.wake_en);
    wake_pd = |(bus.irq & bus.wake_en & PD_WAKE_MASK);
    unique case (s_q.mode)
      rpm_pkg::RPM_RUN: begin
        if (bus.mode_req_valid && !bus.reset_req) begin
          s_d.mode = bus.mode_req;
        end
      end
      rpm_pkg::RPM_IDLE: begin
        if (bus.reset_req || wake_any) begin
          s_d.mode = rpm_pkg::RPM_RUN;
        end
      end
      rpm_pkg::RPM_PD, rpm_pkg::RPM_TPD: begin
        if (bus.reset_req || wake_pd) begin
          s_d.mode = rpm_pkg::RPM_RUN;
        end
      end
    endcase
    low_pwr = (s_d.mode == rpm_pkg::RPM_PD) || (s_d.mode == rpm_pkg::RPM_TPD);
    s_d.cpu_clk_en = (s_d.mode == rpm_pkg::RPM_RUN);
    s_d.periph_clk_en = !low_pwr;
    s_d.osc_main_en = !low_pwr;
    s_d.rc_osc_en = low_pwr ? (bus.rc_sel && bus.rtc_en) : bus.rc_sel;
    s_d.bod_run = bus.bod_en_cfg && (s_d.mode != rpm_pkg::RPM_TPD);
    s_d.cmp_run = !bus.cmp_pd && (s_d.mode != rpm_pkg::RPM_TPD);
    s_d.rtc_run = bus.rtc_en;
    s_d.wdt_run = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= MODE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.mode = s_q.mode;
  assign bus.cpu_clk_en = s_q.cpu_clk_en;
  assign bus.periph_clk_en = s_q.periph_clk_en;
  assign bus.osc_main_en = s_q.osc_main_en;
  assign bus.rc_osc_en = s_q.rc_osc_en;
  assign bus.bod_run = s_q.bod_run;
  assign bus.cmp_run = s_q.cmp_run;
  assign bus.rtc_run = s_q.rtc_run;
  assign bus.wdt_run = s_q.wdt_run;
endmodule // rpm_mode_ctrl

/* hw/rpm_vector_sel.sv */
`timescale 1ns/10ps
// ============================================================
// Start address chosen while reset is active
module rpm_vector_sel (
  // System
  input logic clk_sys,
  input logic rst,
  // Link
  rpm_link_if.vec bus
);
  typedef struct packed {
    logic in_reset, brk_seen, isp_seen;
    logic [15:0] fetch_addr;
  } rpm_vec_state_type;
  localparam rpm_vec_state_type VEC_RST = '{1'b0, 1'b0, 1'b0, rpm_pkg::START_ADDR};
  rpm_vec_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.in_reset = bus.reset_req;
    if (bus.reset_req) begin
      // A new episode forgets the causes of the previous one
      s_d.brk_seen = bus.brk_req | (s_q.in_reset & s_q.brk_seen);
      s_d.isp_seen = (bus.por_active & bus.isp_strap) | (s_q.in_reset & s_q.isp_seen);
      if (s_d.brk_seen || s_d.isp_seen || bus.boot_stat0) begin
        s_d.fetch_addr = {bus.boot_vec, rpm_pkg::BOOT_LOW};
      end else begin
        s_d.fetch_addr = rpm_pkg::START_ADDR;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= VEC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.fetch_addr = s_q.fetch_addr;
endmodule // rpm_vector_sel

/* hw/rpm_top.sv */
`timescale 1ns/10ps
// ============================================================
// How it works
// - Idle keeps peripherals; any enabled interrupt wakes
// - Power-down stops oscillator; reset or subset wakes
// - Brownout, watchdog, comparators, RTC stay on
// - RC oscillator off unless sysclk and RTC
// - Total power-down also stops brownout, comparators
// - Pin enable set: pin is active-low reset
// - Power-up always treats the pin as reset
// - Only power-up overrides the pin enable
// - Six reset sources all reset the core
// - One sticky cause flag per source
// - Writing zero clears a flag; one ignored
// - Power-on sets power-on and brownout flags only
// - Other resets keep uncleared flags set
// - Start at zero or boot vector page
// - Boot page after break, boot bit, forced programming
// - Power-on flag stays until software clears
// - Brownout resets, or interrupts, or is disabled
// - Enabled external interrupt wakes from low power
module rpm_top #(
  parameter int unsigned IRQ_W = 8,
  parameter logic [IRQ_W-1:0] PD_WAKE_MASK = '1,
  parameter int unsigned RST_HOLD = rpm_pkg::RST_HOLD_DEF
) (
  // System
  input logic clk_sys,
  input logic rst,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Reset sources
  input logic por_detect,
  input logic brownout_detect,
  input logic watchdog_reset_req,
  input logic uart_break_req,
  input logic shared_reset_input_pin,
  input logic isp_force_strap,
  // Wake sources
  input logic [IRQ_W-1:0] irq_pending,
  // Core control
  output logic core_reset,
  output logic [15:0] fetch_addr,
  output logic pin_digital_in,
  output logic brownout_irq,
  // Block gating
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_main_en,
  output logic rc_osc_en,
  output logic bod_run,
  output logic cmp_run,
  output logic rtc_run,
  output logic wdt_run
);
  // ============================================================
  // Parameter checks
  if (IRQ_W < 1 || IRQ_W > 16) begin : g_bad_irq
    $error("IRQ_W must lie between 1 and 16");
  end
  if (RST_HOLD < 1 || RST_HOLD > 15) begin : g_bad_hold
    $error("RST_HOLD must lie between 1 and 15");
  end
  // The decode leans on the package layout, so check that as well
  if (rpm_pkg::CS_BRK >= rpm_pkg::CAUSE_W) begin : g_bad_cause
    $error("Every reset source needs a cause bit");
  end
  if (rpm_pkg::ST_RESET >= rpm_pkg::DATA_W) begin : g_bad_status
    $error("Status fields must fit the data word");
  end

  // ============================================================
  // Address decode
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ============================================================
  // State
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic reset_pin_enable;
    logic boe;
    logic boi;
    logic boot_stat0;
    logic [7:0] boot_vec;
    logic cmp_pd;
    logic rtc_en;
    logic rc_sel;
    logic [IRQ_W-1:0] wake_en;
    logic mode_req_valid;
    rpm_pkg::rpm_mode_type mode_req;
    logic sw_reset;
    logic [rpm_pkg::CAUSE_W-1:0] cause;
    logic [3:0] hold_cnt;
    logic core_reset;
    logic pin_digital_in;
    logic brownout_irq;
  } rpm_top_state_type;

  localparam rpm_top_state_type TOP_RST = '{
    pready: 1'b0,
    prdata: 32'h0000_0000,
    pslverr: 1'b0,
    reset_pin_enable: rpm_pkg::RPE_RST,
    boe: rpm_pkg::BOE_RST,
    boi: rpm_pkg::BOI_RST,
    boot_stat0: rpm_pkg::BSTAT_RST,
    boot_vec: rpm_pkg::BVEC_RST,
    cmp_pd: 1'b0,
    rtc_en: 1'b0,
    rc_sel: 1'b0,
    wake_en: '0,
    mode_req_valid: 1'b0,
    mode_req: rpm_pkg::RPM_RUN,
    sw_reset: 1'b0,
    cause: rpm_pkg::CAUSE_POR_VAL,
    hold_cnt: 4'h0,
    core_reset: 1'b1,
    pin_digital_in: 1'b1,
    brownout_irq: 1'b0
  };

  // Four counter bits set the upper limit of RST_HOLD
  localparam logic [3:0] HOLD_LOAD = 4'(RST_HOLD);

  rpm_top_state_type s_q, s_d;
  logic setup_ph;
  logic wr_fire;
  logic wr_mode;
  logic wr_config;
  logic wr_cause;
  logic wr_swrst;
  logic wr_wake;
  logic mapped;
  logic [31:0] rd_word;
  logic pin_is_reset;
  logic reset_req;
  logic [rpm_pkg::CAUSE_W-1:0] src;
  logic [rpm_pkg::CAUSE_W-1:0] cause_clr;
  logic [rpm_pkg::CAUSE_W-1:0] cause_next;

  rpm_link_if #(.IRQ_W(IRQ_W)) lnk ();

  // ============================================================
  // Reset sources
  // Power-up forces the pin into its reset role whatever the config says
  assign pin_is_reset = s_q.reset_pin_enable | por_detect;
  // A pin held low at power-up keeps this source active throughout
  assign src[rpm_pkg::CS_PIN] = pin_is_reset & ~shared_reset_input_pin;
  assign src[rpm_pkg::CS_POR] = por_detect;
  // bod_run already drops in total power-down and when detection is off
  assign src[rpm_pkg::CS_BOD] = lnk.bod_run & ~s_q.boi & brownout_detect;
  assign src[rpm_pkg::CS_WDT] = watchdog_reset_req;
  assign src[rpm_pkg::CS_SW] = s_q.sw_reset;
  assign src[rpm_pkg::CS_BRK] = uart_break_req;
  assign reset_req = |src;

  // ============================================================
  // Write strobes
  // A write lands only at the access edge, never in setup and never after an error
  assign setup_ph = psel & ~penable;
  assign wr_fire = psel & penable & pwrite & s_q.pready & ~s_q.pslverr;
  assign wr_mode = wr_fire & addr_hit(paddr, rpm_pkg::OFF_MODE);
  assign wr_config = wr_fire & addr_hit(paddr, rpm_pkg::OFF_CONFIG);
  assign wr_cause = wr_fire & addr_hit(paddr, rpm_pkg::OFF_CAUSE);
  assign wr_swrst = wr_fire & addr_hit(paddr, rpm_pkg::OFF_SWRST);
  assign wr_wake = wr_fire & addr_hit(paddr, rpm_pkg::OFF_WAKE);

  // ============================================================
  // Cause flags
  assign cause_clr = wr_cause ? ~pwdata[rpm_pkg::CAUSE_W-1:0] : '0;

  // A source active in the clearing cycle keeps its flag
  for (genvar i = 0; i < rpm_pkg::CAUSE_W; i++) begin : g_cause
    assign cause_next[i] = src[i] | (s_q.cause[i] & ~cause_clr[i]);
  end

  // ============================================================
  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped = 1'b1;
    if (addr_hit(paddr, rpm_pkg::OFF_MODE)) begin
      rd_word[rpm_pkg::MD_REQ_LSB +: 2] = lnk.mode;
      rd_word[rpm_pkg::MD_CMP_PD] = s_q.cmp_pd;
      rd_word[rpm_pkg::MD_RTC_EN] = s_q.rtc_en;
      rd_word[rpm_pkg::MD_RC_SEL] = s_q.rc_sel;
    end else if (addr_hit(paddr, rpm_pkg::OFF_CONFIG)) begin
      rd_word[rpm_pkg::CF_RPE] = s_q.reset_pin_enable;
      rd_word[rpm_pkg::CF_BOE] = s_q.boe;
      rd_word[rpm_pkg::CF_BOI] = s_q.boi;
      rd_word[rpm_pkg::CF_BSTAT] = s_q.boot_stat0;
      rd_word[rpm_pkg::CF_BVEC_LSB +: 8] = s_q.boot_vec;
    end else if (addr_hit(paddr, rpm_pkg::OFF_CAUSE)) begin
      rd_word[rpm_pkg::CAUSE_W-1:0] = s_q.cause;
    end else if (addr_hit(paddr, rpm_pkg::OFF_SWRST)) begin
      rd_word = 32'h0000_0000;
    end else if (addr_hit(paddr, rpm_pkg::OFF_WAKE)) begin
      rd_word[IRQ_W-1:0] = s_q.wake_en;
    end else if (addr_hit(paddr, rpm_pkg::OFF_STATUS)) begin
      rd_word[15:0] = lnk.fetch_addr;
      rd_word[rpm_pkg::ST_PIN] = s_q.pin_digital_in;
      rd_word[rpm_pkg::ST_BOIRQ] = s_q.brownout_irq;
      rd_word[rpm_pkg::ST_RESET] = s_q.core_reset;
    end else begin
      mapped = 1'b0;
    end
  end

  // ============================================================
  // Next state
  always_comb begin
    s_d = s_q;
    // Answer one cycle after setup, so the access phase is always one cycle
    s_d.pready = setup_ph;
    if (setup_ph) begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rd_word;
      s_d.pslverr = ~mapped;
    end
    s_d.mode_req_valid = 1'b0;
    s_d.sw_reset = 1'b0;
    if (wr_mode) begin
      if (pwdata[rpm_pkg::MD_REQ_LSB +: 2] != rpm_pkg::RPM_RUN) begin
        s_d.mode_req_valid = 1'b1;
        s_d.mode_req = rpm_pkg::rpm_mode_type'(pwdata[rpm_pkg::MD_REQ_LSB +: 2]);
      end
      s_d.cmp_pd = pwdata[rpm_pkg::MD_CMP_PD];
      s_d.rtc_en = pwdata[rpm_pkg::MD_RTC_EN];
      s_d.rc_sel = pwdata[rpm_pkg::MD_RC_SEL];
    end
    if (wr_config) begin
      s_d.reset_pin_enable = pwdata[rpm_pkg::CF_RPE];
      s_d.boe = pwdata[rpm_pkg::CF_BOE];
      s_d.boi = pwdata[rpm_pkg::CF_BOI];
      s_d.boot_stat0 = pwdata[rpm_pkg::CF_BSTAT];
      s_d.boot_vec = pwdata[rpm_pkg::CF_BVEC_LSB +: 8];
    end
    if (wr_swrst) begin
      s_d.sw_reset = pwdata[rpm_pkg::SW_GO];
    end
    if (wr_wake) begin
      s_d.wake_en = pwdata[IRQ_W-1:0];
    end
    // Power-on wipes older causes; everything else accumulates
    if (por_detect) begin
      s_d.cause = rpm_pkg::CAUSE_POR_VAL;
    end else begin
      s_d.cause = cause_next;
    end
    // Stretch reset so the core always sees a whole reset
    if (reset_req) begin
      s_d.hold_cnt = HOLD_LOAD;
    end else if (s_q.hold_cnt != 4'h0) begin
      s_d.hold_cnt = s_q.hold_cnt - 4'h1;
    end
    s_d.core_reset = reset_req | (s_q.hold_cnt != 4'h0);
    s_d.pin_digital_in = pin_is_reset ? 1'b1 : shared_reset_input_pin;
    s_d.brownout_irq = lnk.bod_run & s_q.boi & brownout_detect;
    // Config bits survive every reset; rtc_en and rc_sel clear only on power-on, other run-time settings on any reset
    if (reset_req) begin
      s_d.mode_req_valid = 1'b0;
      s_d.cmp_pd = 1'b0;
      s_d.wake_en = '0;
    end
    if (por_detect) begin
      s_d.rtc_en = 1'b0;
      s_d.rc_sel = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= TOP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // Link drive
  // The reset request reaches both units unregistered, so mode and vector move on one edge
  assign lnk.reset_req = reset_req;
  assign lnk.mode_req_valid = s_q.mode_req_valid;
  assign lnk.mode_req = s_q.mode_req;
  assign lnk.cmp_pd = s_q.cmp_pd;
  assign lnk.rtc_en = s_q.rtc_en;
  assign lnk.rc_sel = s_q.rc_sel;
  assign lnk.bod_en_cfg = s_q.boe;
  assign lnk.irq = irq_pending;
  assign lnk.wake_en = s_q.wake_en;
  assign lnk.por_active = por_detect;
  assign lnk.isp_strap = isp_force_strap;
  assign lnk.brk_req = src[rpm_pkg::CS_BRK];
  assign lnk.boot_stat0 = s_q.boot_stat0;
  assign lnk.boot_vec = s_q.boot_vec;

  rpm_mode_ctrl #(
    .IRQ_W(IRQ_W),
    .PD_WAKE_MASK(PD_WAKE_MASK)
  ) u_mode (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(lnk.pwr)
  );

  rpm_vector_sel u_vec (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(lnk.vec)
  );

  // ============================================================
  // Outputs
  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign core_reset = s_q.core_reset;
  assign fetch_addr = lnk.fetch_addr;
  assign pin_digital_in = s_q.pin_digital_in;
  assign brownout_irq = s_q.brownout_irq;
  assign cpu_clk_en = lnk.cpu_clk_en;
  assign periph_clk_en = lnk.periph_clk_en;
  assign osc_main_en = lnk.osc_main_en;
  assign rc_osc_en = lnk.rc_osc_en;
  assign bod_run = lnk.bod_run;
  assign cmp_run = lnk.cmp_run;
  assign rtc_run = lnk.rtc_run;
  assign wdt_run = lnk.wdt_run;
endmodule // rpm_top

/* test/rpm_top_assertions.sv */
`timescale 1ns/10ps
// =====
// Port-level checks
module rpm_top_assertions #(
  parameter int unsigned RST_HOLD = 8
) (
  // System
  input logic clk_sys,
  input logic rst,
  // APB
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic pready,
  // Reset side
  input logic por_detect,
  input logic brownout_detect,
  input logic watchdog_reset_req,
  input logic uart_break_req,
  input logic core_reset,
  input logic [15:0] fetch_addr,
  input logic brownout_irq,
  // Gating
  input logic cpu_clk_en,
  input logic periph_clk_en,
  input logic osc_main_en,
  input logic bod_run,
  input logic wdt_run
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Cycles since a visible source; preset on rst so the reset episode never counts
  logic [4:0] since_q;
  always_ff @(posedge clk_sys) begin
    if (rst) since_q <= 5'(RST_HOLD);
    else if (watchdog_reset_req || uart_break_req || por_detect) since_q <= 5'h00;
    else if (since_q != 5'h1F) since_q <= since_q + 5'h01;
  end
  property p_ready; psel && !penable |=> pready; endproperty
  property p_idle; !cpu_clk_en && osc_main_en |-> periph_clk_en; endproperty
  property p_pd; !osc_main_en |-> !cpu_clk_en && !periph_clk_en; endproperty
  property p_wdt; wdt_run; endproperty
  property p_src; watchdog_reset_req || uart_break_req || por_detect |=> core_reset; endproperty
  property p_hold; $fell(core_reset) |-> since_q >= 5'(RST_HOLD); endproperty
  property p_vec; fetch_addr[7:0] == 8'h00; endproperty
  property p_boirq; brownout_irq |-> $past(brownout_detect) && $past(bod_run); endproperty
  property p_mode;
    $fell(cpu_clk_en) |-> $past(psel && penable && pwrite && paddr == 8'h00, 2);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_idle: assert property (p_idle) else $error("idle stopped peripherals");
  a_pd: assert property (p_pd) else $error("core or peripherals run without oscillator");
  a_wdt: assert property (p_wdt) else $error("watchdog stopped");
  a_src: assert property (p_src) else $error("source gave no core reset");
  a_hold: assert property (p_hold) else $error("core reset released early");
  a_vec: assert property (p_vec) else $error("start address low byte not zero");
  a_boirq: assert property (p_boirq) else $error("brownout interrupt without cause");
  a_mode: assert property (p_mode) else $error("core stopped without mode write");
  c_idle: cover property (!cpu_clk_en && osc_main_en);
  c_pd: cover property (!osc_main_en);
  c_boirq: cover property (brownout_irq);
endmodule // rpm_top_assertions

/* test/rpm_ext_reset_model.sv */
`timescale 1ns/10ps
// =====
// Board reset circuit and supply
module rpm_ext_reset_model #(
  parameter int unsigned POR_LEN = 6
) (
  // System
  input logic clk_sys,
  // Commands
  input logic por_start,
  input logic pin_low,
  input logic strap,
  // Pins
  output logic por_detect,
  output logic shared_reset_input_pin,
  output logic isp_force_strap
);
  int unsigned cnt = 0;
  always @(posedge clk_sys) begin
    if (por_start) cnt <= POR_LEN;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  assign por_detect = (cnt != 0);
  assign isp_force_strap = strap && por_detect;
  // Pulled up; never pulled low while power comes up
  assign shared_reset_input_pin = !(pin_low && cnt == 0);
endmodule // rpm_ext_reset_model

/* test/rpm_top_tb_top.sv */
`timescale 1ns/10ps
// =====
// Bench
module rpm_top_tb_top;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, irq_pending;
  logic [31:0] pwdata, prdata, rdv;
  logic brownout_detect, watchdog_reset_req, uart_break_req, por_start, pin_low, strap;
  logic por_detect, pin, in_system_programming_mode, core_reset, pin_digital_in, brownout_irq;
  logic [15:0] fetch_addr;
  logic cpu, per, osc, rc, bod, cmp, rtc, wdt;
  int err_total = 0;
  int n_compared = 0;
  rpm_ext_reset_model i_rpm_ext_reset_model (.clk_sys(clk_sys), .por_start(por_start),
    .pin_low(pin_low), .strap(strap), .por_detect(por_detect),
    .shared_reset_input_pin(pin), .isp_force_strap(in_system_programming_mode));
  rpm_top #(.RST_HOLD(4)) i_rpm_top (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .por_detect(por_detect),
    .brownout_detect(brownout_detect), .watchdog_reset_req(watchdog_reset_req),
    .uart_break_req(uart_break_req), .shared_reset_input_pin(pin), .isp_force_strap(in_system_programming_mode),
    .irq_pending(irq_pending), .core_reset(core_reset), .fetch_addr(fetch_addr),
    .pin_digital_in(pin_digital_in), .brownout_irq(brownout_irq), .cpu_clk_en(cpu),
    .periph_clk_en(per), .osc_main_en(osc), .rc_osc_en(rc), .bod_run(bod), .cmp_run(cmp),
    .rtc_run(rtc), .wdt_run(wdt));
  task wrap_up;
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdv = pslverr ? 32'hFFFFFFFF : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rdv);
  endtask
  // Two edges first: a software request lands only after the write edge
  task settle;
    repeat (2) @(posedge clk_sys);
    while (core_reset !== 1'b0) begin
      @(posedge clk_sys);
    end
  endtask
  task src(input int k);
    @(posedge clk_sys);
    case (k)
      0: watchdog_reset_req <= 1'b1;
      1: uart_break_req <= 1'b1;
      2: brownout_detect <= 1'b1;
      default: pin_low <= 1'b1;
    endcase
    @(posedge clk_sys);
    watchdog_reset_req <= 1'b0;
    uart_break_req <= 1'b0;
    brownout_detect <= 1'b0;
    pin_low <= 1'b0;
    settle();
  endtask
  task gate(input logic [7:0] e);
    repeat (3) @(posedge clk_sys);
    chk("gating", {24'h0, e}, {24'h0, cpu, per, osc, rc, bod, cmp, rtc, wdt});
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #(4 * 5000);
    err_total++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    por_start = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    irq_pending = 8'h00;
    brownout_detect = 1'b0;
    watchdog_reset_req = 1'b0;
    uart_break_req = 1'b0;
    pin_low = 1'b0;
    strap = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    por_start <= 1'b0;
    settle();
    rd(8'h08, 32'h06, "cause");
    rd(8'h04, 32'h0000F002, "config");
    rd(8'h14, 32'h00010000, "status");
    rd(8'h20, 32'hFFFFFFFF, "unmapped");
    xfer(1'b1, 8'h08, 32'h3F);
    rd(8'h08, 32'h06, "cause");
    xfer(1'b1, 8'h08, 32'h04);
    rd(8'h08, 32'h04, "cause");
    src(0);
    rd(8'h08, 32'h0C, "cause");
    xfer(1'b1, 8'h0C, 32'h1);
    settle();
    rd(8'h08, 32'h1C, "cause");
    pin_low <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("core_reset", 32'h0, {31'h0, core_reset});
    rd(8'h14, 32'h00000000, "status");
    pin_low <= 1'b0;
    xfer(1'b1, 8'h04, 32'h0000F003);
    src(3);
    rd(8'h08, 32'h1D, "cause");
    // Brownout flag cleared first, so only its own source or a power-on can set it again
    xfer(1'b1, 8'h08, 32'h3B);
    src(2);
    rd(8'h08, 32'h1D, "cause");
    src(1);
    rd(8'h08, 32'h3D, "cause");
    rd(8'h14, 32'h0001F000, "status");
    src(0);
    rd(8'h14, 32'h00010000, "status");
    xfer(1'b1, 8'h04, 32'h00005A0F);
    brownout_detect <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("bo_irq", 32'h1, {31'h0, brownout_irq});
    chk("core_reset", 32'h0, {31'h0, core_reset});
    brownout_detect <= 1'b0;
    src(0);
    rd(8'h14, 32'h00015A00, "status");
    xfer(1'b1, 8'h04, 32'h00005A03);
    strap <= 1'b1;
    por_start <= 1'b1;
    @(posedge clk_sys);
    por_start <= 1'b0;
    settle();
    strap <= 1'b0;
    rd(8'h08, 32'h06, "cause");
    rd(8'h14, 32'h00015A00, "status");
    xfer(1'b1, 8'h10, 32'h01);
    xfer(1'b1, 8'h00, 32'h01);
    gate(8'b01101101);
    irq_pending <= 8'h02;
    gate(8'b01101101);
    irq_pending <= 8'h03;
    gate(8'b11101101);
    irq_pending <= 8'h00;
    xfer(1'b1, 8'h00, 32'h16);
    gate(8'b00001001);
    irq_pending <= 8'h01;
    gate(8'b11111001);
    irq_pending <= 8'h00;
    xfer(1'b1, 8'h00, 32'h1B);
    gate(8'b00010011);
    src(0);
    gate(8'b11111111);
    wrap_up();
  end
endmodule // rpm_top_tb_top
bind rpm_top rpm_top_assertions #(.RST_HOLD(RST_HOLD)) i_rpm_top_assertions (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .por_detect(por_detect), .brownout_detect(brownout_detect),
  .watchdog_reset_req(watchdog_reset_req), .uart_break_req(uart_break_req),
  .core_reset(core_reset), .fetch_addr(fetch_addr), .brownout_irq(brownout_irq),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_main_en(osc_main_en),
  .bod_run(bod_run), .wdt_run(wdt_run));
